// [core/ussu_core.sv]
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module ussu_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins, raw
  input wire logic serial_in_pin,
  input wire logic serial_clock_pin,
  // Port register bits and pad drive
  input wire ussu_pkg::ussu_port_t port_ctl,
  output ussu_pkg::ussu_pad_t pads,
  output logic port_clock_toggle,
  // System events
  input wire logic timer_match,
  input wire logic global_irq_enable,
  output logic start_irq,
  output logic ovf_irq,
  output logic wake_any_mode,
  output logic wake_idle_only
);

  ussu_pkg::ussu_state_t st_ff;
  ussu_pkg::ussu_state_t nxt_st;

  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic din_s;
  logic scl_s;
  logic start_det;
  logic stop_det;
  logic setup;
  logic access;
  logic hit;
  logic wr_data;
  logic wr_status;
  logic wr_ctrl;
  logic [1:0] cs_new;
  logic soft_strobe;
  logic timer_clk;
  logic ext_shift;
  logic ext_count;
  logic tog_count;
  logic shift;
  logic cnt_inc;
  logic ovf_set;
  logic start_set;
  logic stop_set;
  logic two_wire;
  logic latch_open;
  logic msb_out;
  logic collision;
  logic clr_start;
  logic clr_ovf;
  logic clr_stop;

  function automatic logic sticky(input logic flag, input logic set,
                                  input logic clr);
    // Set beats clear so no event is lost
    sticky = set | (flag & ~clr);
  endfunction

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  ussu_pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_raw({serial_clock_pin, serial_in_pin}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  ussu_cond_det u_cond (
    .clk(clk),
    .reset_n(reset_n),
    .scl_level(lvl[1]),
    .sda_rise(rise[0]),
    .sda_fall(fall[0]),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign din_s = lvl[0];
  assign scl_s = lvl[1];

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = (paddr == ussu_pkg::ADDR_DATA) ||
               (paddr == ussu_pkg::ADDR_STATUS) ||
               (paddr == ussu_pkg::ADDR_CONTROL);
  assign pslverr = access & ~hit;
  assign wr_data = access & pwrite & (paddr == ussu_pkg::ADDR_DATA);
  assign wr_status = access & pwrite & (paddr == ussu_pkg::ADDR_STATUS);
  assign wr_ctrl = access & pwrite & (paddr == ussu_pkg::ADDR_CONTROL);
  assign cs_new = pwdata[ussu_pkg::CR_CS +: 2];

  // ****************************************
  // Clock source decode
  // ****************************************
  // Strobes act on the source written in the same access
  assign soft_strobe = wr_ctrl & pwdata[ussu_pkg::CR_CLK] &
                       (cs_new == ussu_pkg::CS_SOFT);
  assign timer_clk = timer_match &
                     (st_ff.cs == ussu_pkg::CS_TIMER);
  // Inputs are used in every wire mode, outputs may be off
  assign ext_shift = st_ff.cs[1] &
                     (st_ff.cs[0] ? fall[1] : rise[1]);
  assign ext_count = st_ff.cs[1] & ~st_ff.clk_sel &
                     (rise[1] | fall[1]);
  assign tog_count = wr_ctrl & pwdata[ussu_pkg::CR_TC] & cs_new[1] &
                     pwdata[ussu_pkg::CR_CLK];
  assign shift = soft_strobe | timer_clk | ext_shift;
  assign cnt_inc = soft_strobe | timer_clk | ext_count |
                   tog_count;

  // ****************************************
  // Flag events
  // ****************************************
  assign two_wire = st_ff.wm[1];
  assign ovf_set = cnt_inc & (st_ff.cnt == 4'hF) & ~wr_status;
  assign start_set = (two_wire & start_det) |
                     (~two_wire & st_ff.cs[1] & ~st_ff.clk_sel &
                      (rise[1] | fall[1]));
  assign stop_set = two_wire & stop_det;
  assign clr_start = wr_status & pwdata[ussu_pkg::ST_START];
  assign clr_ovf = wr_status & pwdata[ussu_pkg::ST_OVF];
  assign clr_stop = wr_status & pwdata[ussu_pkg::ST_STOP];
  assign collision = st_ff.data[7] ^ din_s;

  // ****************************************
  // Output latch
  // ****************************************
  // External clock: open while the line sits at its idle level
  // for the selected sampling edge, so output moves opposite it
  assign latch_open = ~st_ff.cs[1] | (scl_s == st_ff.cs[0]);
  assign msb_out = latch_open ? st_ff.data[7] : st_ff.latch;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    if (shift) begin
      nxt_st.data = {st_ff.data[6:0], din_s};
    end
    if (wr_data) begin
      nxt_st.data = pwdata[7:0];
    end
    if (latch_open) begin
      nxt_st.latch = st_ff.data[7];
    end
    if (cnt_inc) begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
    if (wr_status) begin
      nxt_st.cnt = pwdata[3:0];
    end
    nxt_st.start_f = sticky(st_ff.start_f, start_set, clr_start);
    nxt_st.ovf_f = sticky(st_ff.ovf_f, ovf_set, clr_ovf);
    nxt_st.stop_f = sticky(st_ff.stop_f, stop_set, clr_stop);
    // Hold starts at the first clock fall after a start
    nxt_st.hold_start = two_wire & nxt_st.start_f &
                        (st_ff.hold_start | fall[1]);
    if (wr_ctrl) begin
      nxt_st.sie = pwdata[ussu_pkg::CR_SIE];
      nxt_st.oie = pwdata[ussu_pkg::CR_OIE];
      nxt_st.wm = pwdata[ussu_pkg::CR_WM +: 2];
      nxt_st.cs = cs_new;
      nxt_st.clk_sel = pwdata[ussu_pkg::CR_CLK];
    end
    nxt_st.toggle = wr_ctrl & pwdata[ussu_pkg::CR_TC];
    if (setup) begin
      nxt_st.prdata = 32'h0000_0000;
      if (paddr == ussu_pkg::ADDR_DATA) begin
        nxt_st.prdata[7:0] = st_ff.data;
      end else if (paddr == ussu_pkg::ADDR_STATUS) begin
        nxt_st.prdata[7:0] = {st_ff.start_f, st_ff.ovf_f, st_ff.stop_f,
                              collision, st_ff.cnt};
      end else if (paddr == ussu_pkg::ADDR_CONTROL) begin
        // Strobe bits read back as zero
        nxt_st.prdata[7:0] = {st_ff.sie, st_ff.oie, st_ff.wm, st_ff.cs,
                              2'h0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '{data: ussu_pkg::DATA_RST, cnt: ussu_pkg::CNT_RST,
                 wm: ussu_pkg::WM_RST, cs: ussu_pkg::CS_RST,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Pads
  // ****************************************
  always_comb begin
    // DO direction always follows its port direction bit
    pads.do_oe = port_ctl.ddr_do;
    pads.do_out = (st_ff.wm == ussu_pkg::WM_THREE) ? msb_out :
                  port_ctl.port_do;
    if (two_wire) begin
      // Open drain: drive low or release
      pads.sda_out = 1'b0;
      pads.sda_oe = port_ctl.ddr_sda &
                    (~msb_out | ~port_ctl.port_sda);
      pads.scl_out = 1'b0;
      pads.scl_oe = port_ctl.ddr_scl &
                    (~port_ctl.port_scl | st_ff.hold_start |
                     ((st_ff.wm == ussu_pkg::WM_TWO_HOLD) &
                      st_ff.ovf_f));
    end else begin
      pads.sda_out = port_ctl.port_sda;
      pads.sda_oe = port_ctl.ddr_sda;
      pads.scl_out = port_ctl.port_scl;
      pads.scl_oe = port_ctl.ddr_scl;
    end
  end

  // ****************************************
  // Events out
  // ****************************************
  assign prdata = st_ff.prdata;
  assign port_clock_toggle = st_ff.toggle;
  // Level outputs, so a pending flag fires once enabled
  assign start_irq = st_ff.start_f & st_ff.sie &
                     global_irq_enable;
  assign ovf_irq = st_ff.ovf_f & st_ff.oie &
                   global_irq_enable;
  assign wake_any_mode = start_irq;
  assign wake_idle_only = ovf_irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_latch_closed;
    st_ff.cs[1] && !latch_open;
  endsequence

  a_write_wins: assert property (
    (wr_data && shift) |=> st_ff.data == $past(pwdata[7:0]))
    else $error("shift overrode data write");

  a_shift_left: assert property (
    (shift && !wr_data) |=>
      st_ff.data == {$past(st_ff.data[6:0]), $past(din_s)})
    else $error("shift did not move toward MSB");

  a_latch_holds: assert property (
    s_latch_closed ##1 s_latch_closed |-> msb_out == $past(msb_out))
    else $error("closed latch let output change");

  a_open_passes: assert property (
    (wr_data && !st_ff.cs[1]) |=> msb_out == $past(pwdata[7]))
    else $error("open latch did not pass new MSB");

  a_ovf_wrap: assert property (
    ovf_set |=> (st_ff.ovf_f && st_ff.cnt == 4'h0))
    else $error("counter wrap missed overflow");

  a_start_sticky: assert property (
    (st_ff.start_f && !clr_start) |=> st_ff.start_f [*1])
    else $error("start flag cleared without write");

  a_edge_start: assert property (
    (st_ff.wm == ussu_pkg::WM_THREE && st_ff.cs[1] && !st_ff.clk_sel
     && rise[1]) |=> st_ff.start_f)
    else $error("clock edge did not set start flag");

  a_start_flag: assert property (
    (two_wire && start_det) |=> st_ff.start_f)
    else $error("start condition not flagged");

  a_stop_set: assert property (
    (two_wire && stop_det) |=> (st_ff.stop_f && !$rose(start_irq)))
    else $error("stop condition not flagged");

  a_pending_irq: assert property (
    (wr_ctrl && pwdata[ussu_pkg::CR_OIE] && st_ff.ovf_f && !clr_ovf
     && global_irq_enable) |=> ##0 (!global_irq_enable || ovf_irq))
    else $error("pending overflow did not interrupt");

  a_ovf_hold: assert property (
    (st_ff.wm == ussu_pkg::WM_TWO_HOLD && st_ff.ovf_f &&
     port_ctl.ddr_scl) |-> (pads.scl_oe && !pads.scl_out))
    else $error("overflow did not hold clock line");

  a_off_port: assert property (
    (st_ff.wm == ussu_pkg::WM_OFF) |->
      (pads.scl_out == port_ctl.port_scl &&
       pads.do_out == port_ctl.port_do))
    else $error("mode zero overrode port pins");

  a_collision: assert property (
    (setup && paddr == ussu_pkg::ADDR_STATUS) |=>
      prdata[ussu_pkg::ST_COLL] == $past(collision))
    else $error("collision bit wrong");

endmodule // ussu_core

// [core/ussu_pkg.sv]
package ussu_pkg;

  // ****************************************
  // Register map over APB
  // ****************************************
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [1:0] WM_RST = 2'h0;
  localparam logic [1:0] CS_RST = 2'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ST_START = 7;
  localparam int ST_OVF = 6;
  localparam int ST_STOP = 5;
  localparam int ST_COLL = 4;
  localparam int CR_SIE = 7;
  localparam int CR_OIE = 6;
  localparam int CR_WM = 4;
  localparam int CR_CS = 2;
  localparam int CR_CLK = 1;
  localparam int CR_TC = 0;

  // ****************************************
  // Mode encodings
  // ****************************************
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic port_do;
    logic ddr_do;
    logic port_sda;
    logic ddr_sda;
    logic port_scl;
    logic ddr_scl;
  } ussu_port_t;

  typedef struct packed {
    logic do_out;
    logic do_oe;
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } ussu_pad_t;

  typedef struct packed {
    logic [1:0] f1;
    logic [1:0] f2;
    logic [1:0] f3;
    logic [1:0] lvl;
  } ussu_sync_t;

  typedef struct packed {
    logic [7:0] data;
    logic latch;
    logic [3:0] cnt;
    logic start_f;
    logic ovf_f;
    logic stop_f;
    logic sie;
    logic oie;
    logic [1:0] wm;
    logic [1:0] cs;
    logic clk_sel;
    logic hold_start;
    logic toggle;
    logic [31:0] prdata;
  } ussu_state_t;

endpackage

// [core/ussu_pin_sync.sv]
`timescale 1ns/1ps
module ussu_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins: bit 1 clock, bit 0 data
  input wire logic [1:0] pin_raw,
  // Filtered levels and change pulses
  output logic [1:0] level,
  output logic [1:0] rise,
  output logic [1:0] fall
);

  ussu_pkg::ussu_sync_t st_ff;
  ussu_pkg::ussu_sync_t nxt_st;
  logic [1:0] agree;

  // ****************************************
  // Three stages; change counts when 2 and 3 agree
  // ****************************************
  assign agree = ~(st_ff.f2 ^ st_ff.f3);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.f1 = pin_raw;
    nxt_st.f2 = st_ff.f1;
    nxt_st.f3 = st_ff.f2;
    nxt_st.lvl = (agree & st_ff.f3) | (~agree & st_ff.lvl);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.lvl;
  assign rise = agree & st_ff.f3 & ~st_ff.lvl;
  assign fall = agree & ~st_ff.f3 & st_ff.lvl;

  a_level_agreed: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_ff.lvl != $past(st_ff.lvl)) |->
      (((st_ff.lvl ^ $past(st_ff.lvl)) & ~$past(agree)) == 2'h0))
    else $error("level changed without agreeing stages");

endmodule // ussu_pin_sync

// [core/ussu_cond_det.sv]
`timescale 1ns/1ps
module ussu_cond_det (
  // Clock and reset, for checks only
  input wire logic clk,
  input wire logic reset_n,
  // Filtered line state
  input wire logic scl_level,
  input wire logic sda_rise,
  input wire logic sda_fall,
  // Bus conditions, one-cycle pulses
  output logic start_det,
  output logic stop_det
);

  // ****************************************
  // Data edges while the clock line is high
  // ****************************************
  assign start_det = sda_fall & scl_level;
  assign stop_det = sda_rise & scl_level;

  a_start_cause: assert property (
    @(posedge clk) disable iff (!reset_n)
    start_det |-> (scl_level && sda_fall && !stop_det))
    else $error("start seen without falling data under high clock");

endmodule // ussu_cond_det

// [sim/ussu_remote.sv]
`timescale 1ns/1ps
module ussu_remote (
  // Link lines toward the unit
  output logic sck,
  output logic sda,
  // Data output of the unit
  input wire logic do_pin
);
  // ****
  // Remote master, 400 ns link clock
  // ****
  localparam time HALF = 200;

  initial begin
    sck = 1'b0;
    sda = 1'b1;
  end

  // Sampled late in the high phase: the unit's latch is closed then
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sda = tx[i];
      #HALF;
      sck = 1'b1;
      #HALF;
      rx[i] = do_pin;
      sck = 1'b0;
    end
    // Clock stands low after the frame; data shows no stale bit
    sda = ~tx[0];
  endtask

  // Two-wire lines rest high through the pull-ups
  task automatic idle_high();
    sda = 1'b1;
    #HALF;
    sck = 1'b1;
    #HALF;
  endtask

  task automatic start_cond();
    sda = 1'b0;
    #HALF;
    sck = 1'b0;
    #HALF;
  endtask

  task automatic stop_cond();
    sda = 1'b0;
    #HALF;
    sck = 1'b1;
    #HALF;
    sda = 1'b1;
    #HALF;
  endtask
endmodule // ussu_remote

// [sim/ussu_core_bench.sv]
`timescale 1ns/1ps
module ussu_core_bench;
  // ****
  // Hookup
  // ****
  localparam logic [7:0] DAT = ussu_pkg::ADDR_DATA;
  localparam logic [7:0] STA = ussu_pkg::ADDR_STATUS;
  localparam logic [7:0] CTL = ussu_pkg::ADDR_CONTROL;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  logic timer_match, gie, tgl, s_irq, o_irq, w_any, w_idle;
  logic p_sck, p_sda;
  ussu_pkg::ussu_port_t port_ctl;
  ussu_pkg::ussu_pad_t pads;
  int error_cnt, compares, cycles;
  // Open-drain lines: either party may pull low
  wire logic sda_pull = pads.sda_oe & ~pads.sda_out;
  wire logic scl_pull = pads.scl_oe & ~pads.scl_out;
  wire logic sda_line = p_sda & ~sda_pull;
  wire logic scl_line = p_sck & ~scl_pull;

  ussu_core i_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(sda_line),
    .serial_clock_pin(scl_line), .port_ctl(port_ctl), .pads(pads),
    .port_clock_toggle(tgl), .timer_match(timer_match),
    .global_irq_enable(gie), .start_irq(s_irq), .ovf_irq(o_irq),
    .wake_any_mode(w_any), .wake_idle_only(w_idle)
  );

  ussu_remote i_remote (.sck(p_sck), .sda(p_sda), .do_pin(pads.do_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd & m, exp);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_match = 1'b0;
    gie = 1'b0;
    port_ctl = 6'h32;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // Let the pin synchroniser fill before status is read
    repeat (4) @(posedge clk);
    rdc(DAT, 32'h0, '1, "data rst");
    rdc(CTL, 32'h0, '1, "ctrl rst");
    rdc(STA, 32'h10, '1, "status rst");
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    chk("pready", 32'(pready), 32'h1);
    chk("pads", 32'(pads), 32'(port_ctl));
    wr(DAT, 32'hA5);
    rdc(DAT, 32'hA5, '1, "data rw");
    wr(CTL, 32'h10);
    @(negedge clk);
    chk("do msb", 32'(pads.do_out), 32'h1);
    wr(DAT, 32'h25);
    @(negedge clk);
    chk("do new", 32'(pads.do_out), 32'h0);
    wr(STA, 32'h0F);
    rdc(STA, 32'h0F, 32'h0F, "count rw");
    wr(CTL, 32'h12);
    rdc(DAT, 32'h4B, '1, "strobe");
    rdc(STA, 32'h40, 32'hEF, "wrap");
    wr(STA, 32'h00);
    rdc(STA, 32'h40, 32'hEF, "zero kept");
    gie <= 1'b1;
    wr(CTL, 32'h50);
    @(negedge clk);
    chk("ovf irq", 32'({o_irq,w_idle,s_irq,w_any}), 32'hC);
    wr(STA, 32'h40);
    rdc(STA, 32'h00, 32'hEF, "ovf clr");
    chk("ovf off", 32'(o_irq), 32'h0);
    wr(CTL, 32'h14);
    @(posedge clk);
    timer_match <= 1'b1;
    @(posedge clk);
    timer_match <= 1'b0;
    rdc(DAT, 32'h97, '1, "timer");
    rdc(STA, 32'h01, 32'h0F, "timer cnt");
    fork
      wr(DAT, 32'h5A);
      begin
        repeat (2) @(posedge clk);
        timer_match <= 1'b1;
        @(posedge clk);
        timer_match <= 1'b0;
      end
    join
    rdc(DAT, 32'h5A, '1, "write wins");
    wr(CTL, 32'h18);
    wr(DAT, 32'h3C);
    wr(STA, 32'hC0);
    @(negedge clk);
    i_remote.xfer(8'hC5, rx);
    repeat (8) @(posedge clk);
    chk("master rx", 32'(rx), 32'h3C);
    rdc(DAT, 32'hC5, '1, "slave rx");
    rdc(STA, 32'hC0, 32'hEF, "edges");
    wr(CTL, 32'h98);
    @(negedge clk);
    chk("start irq", 32'({s_irq, w_any}), 32'h3);
    @(posedge clk);
    gie <= 1'b0;
    @(negedge clk);
    chk("gie off", 32'(s_irq), 32'h0);
    wr(STA, 32'hC0);
    rdc(STA, 32'h00, 32'hEF, "flags clr");
    wr(CTL, 32'h1B);
    @(negedge clk);
    chk("toggle", 32'(tgl), 32'h1);
    rdc(STA, 32'h01, 32'h0F, "tc count");
    @(negedge clk);
    i_remote.idle_high();
    wr(DAT, 32'hFF);
    port_ctl <= 6'h3F;
    gie <= 1'b1;
    wr(CTL, 32'hEC);
    wr(STA, 32'hF0);
    @(negedge clk);
    i_remote.start_cond();
    repeat (8) @(posedge clk);
    chk("scl hold", 32'(scl_pull), 32'h1);
    chk("start irq", 32'(s_irq), 32'h1);
    rdc(STA, 32'h80, 32'hE0, "start");
    wr(STA, 32'h80);
    @(negedge clk);
    chk("scl free", 32'(scl_pull), 32'h0);
    @(negedge clk);
    i_remote.stop_cond();
    repeat (8) @(posedge clk);
    rdc(STA, 32'h20, 32'hE0, "stop");
    chk("no irq", 32'({s_irq, o_irq}), 32'h0);
    // Toggle strobe wraps the counter in hold mode
    wr(STA, 32'h0F);
    wr(CTL, 32'h3B);
    @(negedge clk);
    chk("ovf hold", 32'(scl_pull), 32'h1);
    wr(STA, 32'h40);
    @(negedge clk);
    chk("ovf free", 32'(scl_pull), 32'h0);
    repeat (8) @(posedge clk);
    wr(CTL, 32'h2C);
    wr(DAT, 32'h00);
    @(negedge clk);
    chk("sda pull", 32'(sda_pull), 32'h1);
    end_of_test();
  end
endmodule // ussu_core_bench
